// ==== core/fss_defines.svh ====
`ifndef FSS_DEFINES_SVH
`define FSS_DEFINES_SVH

// register offsets, as seen by the master's object access
`define FSS_OFS_STATUS_WORD 16'h1b04
`define FSS_OFS_WARN_LATCHED 16'h1c18
`define FSS_OFS_RECENT_CODE 16'h1c1a

// status word bit positions
`define FSS_SW_STATE_LO 0
`define FSS_SW_VOLT_EN 4
`define FSS_SW_STATE_5 5
`define FSS_SW_STATE_6 6
`define FSS_SW_CLASS0 7
`define FSS_SW_PAUSE 8
`define FSS_SW_REMOTE 9
`define FSS_SW_MODE_10 10
`define FSS_SW_RSVD_11 11
`define FSS_SW_MODE_12 12
`define FSS_SW_FAULT 13
`define FSS_SW_MOTION_DONE 14
`define FSS_SW_HOMING_OK 15

// latched warning bits that clear by themselves, and reserved ones
`define FSS_WARN_SELF_CLEAR 16'h2c00
`define FSS_WARN_RSVD 16'h8008

// reset values
`define FSS_ZERO16 16'h0000

`endif

// ==== core/fss_pkg.sv ====
`default_nettype none
package fss_pkg;

   // application-layer communication states
   typedef enum logic [2:0] {
      FSS_INIT,
      FSS_PREOP,
      FSS_SAFEOP,
      FSS_OP,
      FSS_BOOT
   } fss_state_type;

endpackage
`default_nettype wire

// ==== core/fss_warn_latch.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fss_defines.svh"

module fss_warn_latch #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] warn_src,
   input wire logic err_clear,
   input wire logic [15:0] warn_code,
   input wire logic warn_code_vld,
   output logic [WIDTH-1:0] latched_warning_bits,
   output logic [15:0] recent_class0_code
);

   // *****************************************
   // constant masks
   // *****************************************
   localparam logic [WIDTH-1:0] SELF_MASK = WIDTH'(`FSS_WARN_SELF_CLEAR);
   localparam logic [WIDTH-1:0] RSVD_MASK = WIDTH'(`FSS_WARN_RSVD);

   logic [WIDTH-1:0] bits_ff;
   logic [WIDTH-1:0] nxt_bits;
   logic [15:0] code_ff;
   logic [15:0] nxt_code;

   // *****************************************
   // per-bit latch
   // *****************************************
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         // set beats clear so a fresh warning is never lost
         assign nxt_bits[i] = RSVD_MASK[i] ? 1'b0 :
            warn_src[i] ? 1'b1 :
            (err_clear || SELF_MASK[i]) ? 1'b0 :
            bits_ff[i];
      end
   endgenerate

   // newest code wins over clear; zero means none yet
   assign nxt_code = warn_code_vld ? warn_code :
      err_clear ? `FSS_ZERO16 : code_ff;

   // register stage, frozen while clock enable is low
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bits_ff <= '0;
         code_ff <= `FSS_ZERO16;
      end else if (clk_en) begin
         bits_ff <= nxt_bits;
         code_ff <= nxt_code;
      end
   end

   assign latched_warning_bits = bits_ff;
   assign recent_class0_code = code_ff;

endmodule // fss_warn_latch
`default_nettype wire

// ==== core/fss_status_tx.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fss_defines.svh"

module fss_status_tx (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic tx_enable,
   input wire logic [15:0] status_now,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [15:0] tx_word
);

   // *****************************************
   // change-driven sender
   // *****************************************
   logic [15:0] last_ff;
   logic pend_ff;
   logic [15:0] word_ff;
   wire changed = (status_now != last_ff);
   wire fire = pend_ff && tx_ready;

   // compare against last queued value, queue on difference
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         last_ff <= `FSS_ZERO16;
         pend_ff <= 1'b0;
         word_ff <= `FSS_ZERO16;
      end else if (clk_en) begin
         if (!tx_enable) begin
            // no process data outside input update
            pend_ff <= 1'b0;
         end else if (changed && !pend_ff) begin
            pend_ff <= 1'b1;
            word_ff <= status_now;
            last_ff <= status_now;
         end else if (fire) begin
            pend_ff <= 1'b0;
         end
      end
   end

   assign tx_valid = pend_ff;
   assign tx_word = word_ff;

endmodule // fss_status_tx
`default_nettype wire

// ==== core/fss_top.sv ====
// How it works
// - init: no application exchange with master
// - pre-op: mailbox only, no process data
// - stay pre-op without valid mapping
// - safe-op: send inputs, drop outputs
// - op: send inputs, apply outputs
// - each step runs its local service
// - op to pre-op stops both updates
// - safe-op to init stops inputs, mailbox
// - op to init stops all, mailbox
// - status word sent on change only
// - bit 7 set for class 0 error
// - bit 13 set for class 1-4
// - fixed status word bit layout
// - warning bit latches when source active
// - error clear wipes latched warnings
// - bits 10,11,13 clear on their own
// - warning bit sources, 3 and 15 reserved
// - recent class-0 code kept until clear
`timescale 1ns/10ps
`default_nettype none
`include "fss_defines.svh"

module fss_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // state request from the master
   input wire logic req_valid,
   input wire fss_pkg::fss_state_type req_state,
   input wire logic map_valid,
   // process data from and to the master
   input wire logic out_pd_valid,
   input wire logic [15:0] out_pd_data,
   input wire logic [15:0] in_pd_data,
   input wire logic status_ready,
   // drive conditions
   input wire logic [3:0] drv_state_bits,
   input wire logic volt_enabled,
   input wire logic pause_active,
   input wire logic remote,
   input wire logic [1:0] mode_bits,
   input wire logic motion_done,
   input wire logic homing_valid,
   input wire logic class0_active,
   input wire logic fault_active,
   input wire logic [15:0] warn_src,
   input wire logic [15:0] warn_code,
   input wire logic warn_code_vld,
   input wire logic err_clear,
   // register read port
   input wire logic [15:0] reg_addr,
   output logic [15:0] reg_rdata,
   output logic reg_hit,
   // state and services
   output fss_pkg::fss_state_type cur_state,
   output logic mbox_on,
   output logic in_upd_on,
   output logic out_upd_on,
   output logic boot_mode,
   output logic dev_restart,
   output logic req_refused,
   output logic in_pd_valid,
   output logic [15:0] in_pd_word,
   output logic out_apply_valid,
   output logic [15:0] out_apply_data,
   output logic status_valid,
   output logic [15:0] status_word
);

   // *****************************************
   // state register and transition legality
   // *****************************************
   fss_pkg::fss_state_type state_ff;
   fss_pkg::fss_state_type nxt_state;
   logic mbox_ff;
   logic inupd_ff;
   logic outupd_ff;
   logic boot_ff;
   logic restart_ff;
   logic refused_ff;
   logic nxt_mbox;
   logic nxt_inupd;
   logic nxt_outupd;
   logic nxt_restart;

   // legal single steps and the documented shortcuts
   wire from_i = (state_ff == fss_pkg::FSS_INIT);
   wire from_p = (state_ff == fss_pkg::FSS_PREOP);
   wire from_s = (state_ff == fss_pkg::FSS_SAFEOP);
   wire from_o = (state_ff == fss_pkg::FSS_OP);
   wire from_b = (state_ff == fss_pkg::FSS_BOOT);
   wire to_i = (req_state == fss_pkg::FSS_INIT);
   wire to_p = (req_state == fss_pkg::FSS_PREOP);
   wire to_s = (req_state == fss_pkg::FSS_SAFEOP);
   wire to_o = (req_state == fss_pkg::FSS_OP);
   wire to_b = (req_state == fss_pkg::FSS_BOOT);

   wire tr_ip = from_i && to_p;
   wire tr_pi = from_p && to_i;
   wire tr_ps = from_p && to_s && map_valid;
   wire tr_sp = from_s && to_p;
   wire tr_so = from_s && to_o;
   wire tr_os = from_o && to_s;
   wire tr_op = from_o && to_p;
   wire tr_si = from_s && to_i;
   wire tr_oi = from_o && to_i;
   wire tr_ib = from_i && to_b;
   wire tr_bi = from_b && to_i;

   wire legal = tr_ip || tr_pi || tr_ps || tr_sp || tr_so || tr_os ||
      tr_op || tr_si || tr_oi || tr_ib || tr_bi;
   wire take = req_valid && legal;
   wire same = req_valid && (req_state == state_ff);

   // next state follows only legal requests
   assign nxt_state = take ? req_state : state_ff;

   // *****************************************
   // local management services
   // *****************************************
   // mailbox starts on init to pre-op, stops on any entry to init
   assign nxt_mbox = tr_ip ? 1'b1 :
      (tr_pi || tr_si || tr_oi) ? 1'b0 :
      mbox_ff;                                 // keeps it on op to pre-op
   // input update starts on pre-op to safe-op
   assign nxt_inupd = tr_ps ? 1'b1 :
      (tr_sp || tr_op || tr_si || tr_oi) ? 1'b0 :
      inupd_ff;
   // output update starts on safe-op to op
   assign nxt_outupd = tr_so ? 1'b1 :
      (tr_os || tr_op || tr_oi) ? 1'b0 :
      outupd_ff;
   // restart is a one-cycle pulse on leaving bootstrap
   assign nxt_restart = take && tr_bi;

   // state and service flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= fss_pkg::FSS_INIT;
         mbox_ff <= 1'b0;
         inupd_ff <= 1'b0;
         outupd_ff <= 1'b0;
         boot_ff <= 1'b0;
         restart_ff <= 1'b0;
         refused_ff <= 1'b0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         mbox_ff <= take ? nxt_mbox : mbox_ff;
         inupd_ff <= take ? nxt_inupd : inupd_ff;
         outupd_ff <= take ? nxt_outupd : outupd_ff;
         boot_ff <= take ? tr_ib : boot_ff;
         restart_ff <= nxt_restart;
         // a refusal pulses for one cycle
         refused_ff <= req_valid && !legal && !same;
      end
   end

   // *****************************************
   // process data gating
   // *****************************************
   logic in_v_ff;
   logic [15:0] in_d_ff;
   logic out_v_ff;
   logic [15:0] out_d_ff;

   // init and pre-op carry no process data at all
   wire send_inputs = inupd_ff;
   // outputs acted on only in op; safe-op drops them
   wire accept_out = outupd_ff && out_pd_valid;

   // input and output process data stage
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         in_v_ff <= 1'b0;
         in_d_ff <= `FSS_ZERO16;
         out_v_ff <= 1'b0;
         out_d_ff <= `FSS_ZERO16;
      end else if (clk_en) begin
         in_v_ff <= send_inputs;
         in_d_ff <= send_inputs ? in_pd_data : in_d_ff;
         out_v_ff <= accept_out;
         out_d_ff <= accept_out ? out_pd_data : out_d_ff;
      end
   end

   // *****************************************
   // status word assembly
   // *****************************************
   logic [15:0] sw_now;
   always_comb begin
      sw_now = `FSS_ZERO16;
      sw_now[`FSS_SW_STATE_LO +: 4] = drv_state_bits;
      sw_now[`FSS_SW_VOLT_EN] = volt_enabled;
      sw_now[`FSS_SW_STATE_5] = 1'b0;
      sw_now[`FSS_SW_STATE_6] = 1'b0;
      sw_now[`FSS_SW_CLASS0] = class0_active;
      sw_now[`FSS_SW_PAUSE] = pause_active;
      sw_now[`FSS_SW_REMOTE] = remote;
      sw_now[`FSS_SW_MODE_10] = mode_bits[0];
      sw_now[`FSS_SW_RSVD_11] = 1'b0;
      sw_now[`FSS_SW_MODE_12] = mode_bits[1];
      sw_now[`FSS_SW_FAULT] = fault_active;
      sw_now[`FSS_SW_MOTION_DONE] = motion_done;
      sw_now[`FSS_SW_HOMING_OK] = homing_valid;
   end

   // status word register; bits 5,6 left zero as no inputs drive them
   logic [15:0] sw_ff;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sw_ff <= `FSS_ZERO16;
      end else if (clk_en) begin
         sw_ff <= sw_now;
      end
   end

   // *****************************************
   // sub-blocks
   // *****************************************
   logic [15:0] warn_bits;
   logic [15:0] last_code;
   logic tx_v;
   logic [15:0] tx_w;

   fss_warn_latch #(
      .WIDTH(16)
   ) u_warn (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .warn_src(warn_src),
      .err_clear(err_clear),
      .warn_code(warn_code),
      .warn_code_vld(warn_code_vld),
      .latched_warning_bits(warn_bits),
      .recent_class0_code(last_code)
   );

   // sent only while input update runs
   fss_status_tx u_tx (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .tx_enable(inupd_ff),
      .status_now(sw_ff),
      .tx_ready(status_ready),
      .tx_valid(tx_v),
      .tx_word(tx_w)
   );

   // *****************************************
   // register read port
   // *****************************************
   wire hit_sw = (reg_addr == `FSS_OFS_STATUS_WORD);
   wire hit_wl = (reg_addr == `FSS_OFS_WARN_LATCHED);
   wire hit_rc = (reg_addr == `FSS_OFS_RECENT_CODE);
   wire [15:0] rd_mux = hit_sw ? sw_ff : hit_wl ? warn_bits :
      hit_rc ? last_code : `FSS_ZERO16;

   // registered read data, unmapped reads zero with hit low
   logic [15:0] rdata_ff;
   logic hit_ff;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_ff <= `FSS_ZERO16;
         hit_ff <= 1'b0;
      end else if (clk_en) begin
         rdata_ff <= rd_mux;
         hit_ff <= hit_sw || hit_wl || hit_rc;
      end
   end

   // *****************************************
   // outputs, all from flops
   // *****************************************
   assign cur_state = state_ff;
   assign mbox_on = mbox_ff;
   assign in_upd_on = inupd_ff;
   assign out_upd_on = outupd_ff;
   assign boot_mode = boot_ff;
   assign dev_restart = restart_ff;
   assign req_refused = refused_ff;
   assign in_pd_valid = in_v_ff;
   assign in_pd_word = in_d_ff;
   assign out_apply_valid = out_v_ff;
   assign out_apply_data = out_d_ff;
   assign status_valid = tx_v;
   assign status_word = tx_w;
   assign reg_rdata = rdata_ff;
   assign reg_hit = hit_ff;

endmodule // fss_top
`default_nettype wire

// ==== dv/fss_props.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************
// state and status checker
// ****************
module fss_props (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic req_valid,
   input wire fss_pkg::fss_state_type req_state,
   input wire logic map_valid,
   input wire logic out_pd_valid,
   input wire logic [15:0] out_pd_data,
   input wire logic status_ready,
   input wire logic class0_active,
   input wire logic fault_active,
   input wire logic [15:0] warn_src,
   input wire logic err_clear,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_rdata,
   input wire fss_pkg::fss_state_type cur_state,
   input wire logic mbox_on,
   input wire logic in_upd_on,
   input wire logic out_upd_on,
   input wire logic out_apply_valid,
   input wire logic [15:0] out_apply_data,
   input wire logic status_valid,
   input wire logic [15:0] status_word
);
   // one clock domain, so one default clock and reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // accepted-looking request from one state to another
   sequence s_req(f, t);
      clk_en && req_valid && cur_state == f && req_state == t;
   endsequence
   // source seen, no clear, then warnings read back
   sequence s_warn1;
      clk_en && warn_src[1] ##1 clk_en && !err_clear ##1 clk_en && reg_addr == 16'h1c18;
   endsequence
   // clear with all sources quiet, then a read of the latch
   sequence s_clr;
      clk_en && err_clear && warn_src == 16'h0000 ##1 clk_en && reg_addr == 16'h1c18;
   endsequence
   property p_init_quiet;
      cur_state == fss_pkg::FSS_INIT |-> !mbox_on && !in_upd_on && !out_upd_on;
   endproperty
   a_init_quiet: assert property (p_init_quiet) else $error("init with a service on");
   property p_preop;
      cur_state == fss_pkg::FSS_PREOP |-> mbox_on && !in_upd_on && !out_upd_on;
   endproperty
   a_preop: assert property (p_preop) else $error("pre-op services wrong");
   property p_no_map;
      s_req(fss_pkg::FSS_PREOP, fss_pkg::FSS_SAFEOP) ##0 !map_valid
         |=> cur_state == fss_pkg::FSS_PREOP;
   endproperty
   a_no_map: assert property (p_no_map) else $error("left pre-op without mapping");
   property p_drop;
      clk_en && !out_upd_on |=> !out_apply_valid;
   endproperty
   a_drop: assert property (p_drop) else $error("outputs applied outside op");
   property p_apply;
      clk_en && out_upd_on && out_pd_valid
         |=> out_apply_valid && out_apply_data == $past(out_pd_data);
   endproperty
   a_apply: assert property (p_apply) else $error("outputs not applied in op");
   property p_op_pre;
      s_req(fss_pkg::FSS_OP, fss_pkg::FSS_PREOP) |=> mbox_on && !in_upd_on && !out_upd_on;
   endproperty
   a_op_pre: assert property (p_op_pre) else $error("op to pre-op services wrong");
   property p_to_init;
      clk_en && req_valid && req_state == fss_pkg::FSS_INIT
         && (cur_state == fss_pkg::FSS_SAFEOP || cur_state == fss_pkg::FSS_OP)
         |=> cur_state == fss_pkg::FSS_INIT && !mbox_on && !in_upd_on && !out_upd_on;
   endproperty
   a_to_init: assert property (p_to_init) else $error("drop to init wrong");
   property p_sw_err;
      (clk_en && reg_addr == 16'h1b04 && $stable(class0_active) && $stable(fault_active))[*2]
         |=> reg_rdata[7] == $past(class0_active) && reg_rdata[13] == $past(fault_active);
   endproperty
   a_sw_err: assert property (p_sw_err) else $error("error class bits wrong");
   property p_status_hold;
      status_valid && !status_ready && in_upd_on |=> status_valid && $stable(status_word);
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status word not held");
   property p_warn_set;
      s_warn1 |=> reg_rdata[1];
   endproperty
   a_warn_set: assert property (p_warn_set) else $error("warning bit not latched");
   property p_self_clear;
      (clk_en && reg_addr == 16'h1c18 && !warn_src[11])[*2] |=> !reg_rdata[11];
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("bit 11 kept");
   property p_clear;
      s_clr |=> reg_rdata == 16'h0000;
   endproperty
   a_clear: assert property (p_clear) else $error("warnings not cleared");
endmodule // fss_props
bind fss_top fss_props props_u (.clk, .sys_rst, .clk_en, .req_valid, .req_state, .map_valid,
   .out_pd_valid, .out_pd_data, .status_ready, .class0_active, .fault_active, .warn_src,
   .err_clear, .reg_addr, .reg_rdata, .cur_state, .mbox_on, .in_upd_on, .out_upd_on,
   .out_apply_valid, .out_apply_data, .status_valid, .status_word);
`default_nettype wire

// ==== dv/fss_master.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************
// fieldbus master stand-in
// ****************
module fss_master (
   input wire logic clk,
   input wire logic stall,
   output logic req_valid,
   output fss_pkg::fss_state_type req_state,
   output logic out_pd_valid,
   output logic [15:0] out_pd_data,
   output logic status_ready
);
   // a stalled link holds status words back
   assign status_ready = !stall;
   // idle master, no requests before reset ends
   initial begin
      req_valid = 1'b0;
      req_state = fss_pkg::FSS_INIT;
      out_pd_valid = 1'b0;
      out_pd_data = 16'h0000;
   end
   // one state request, held over one taking edge
   task automatic request(input fss_pkg::fss_state_type st);
      @(posedge clk);
      #1;
      req_valid = 1'b1;
      req_state = st;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
   endtask
   // one output word; data line scrambled once released
   task automatic send_out(input logic [15:0] d);
      @(posedge clk);
      #1;
      out_pd_valid = 1'b1;
      out_pd_data = d;
      @(posedge clk);
      #1;
      out_pd_valid = 1'b0;
      out_pd_data = ~d;
   endtask
endmodule // fss_master
`default_nettype wire

// ==== dv/fss_top_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`define FSS_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
// ****************
// state and status bench
// ****************
module fss_top_test;
   localparam fss_pkg::fss_state_type st_i = fss_pkg::FSS_INIT;
   localparam fss_pkg::fss_state_type st_p = fss_pkg::FSS_PREOP;
   localparam fss_pkg::fss_state_type st_s = fss_pkg::FSS_SAFEOP;
   localparam fss_pkg::fss_state_type st_o = fss_pkg::FSS_OP;
   localparam fss_pkg::fss_state_type st_b = fss_pkg::FSS_BOOT;
   logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, map_valid = 1'b0, stall = 1'b1;
   logic volt_enabled = 1'b0, pause_active = 1'b0, remote = 1'b0, motion_done = 1'b0;
   logic homing_valid = 1'b0, class0_active = 1'b0, fault_active = 1'b0;
   logic warn_code_vld = 1'b0, err_clear = 1'b0;
   logic [3:0] drv_state_bits = 4'h0;
   logic [1:0] mode_bits = 2'h0;
   logic [15:0] in_pd_data = 16'h1234, warn_src = 16'h0000, warn_code = 16'h0000;
   logic [15:0] reg_addr = 16'h0000;
   // driven by the master model or the block
   logic req_valid, out_pd_valid, status_ready, reg_hit, mbox_on, in_upd_on, out_upd_on;
   logic boot_mode, dev_restart, req_refused, in_pd_valid, out_apply_valid, status_valid;
   logic [15:0] out_pd_data, reg_rdata, in_pd_word, out_apply_data, status_word;
   fss_pkg::fss_state_type req_state, cur_state;
   int n_mismatch = 0;
   int samples_checked = 0;
   fss_master master_u (.clk, .stall, .req_valid, .req_state, .out_pd_valid, .out_pd_data,
      .status_ready);
   fss_top dut_u (.clk, .sys_rst, .clk_en, .req_valid, .req_state, .map_valid, .out_pd_valid,
      .out_pd_data, .in_pd_data, .status_ready, .drv_state_bits, .volt_enabled, .pause_active,
      .remote, .mode_bits, .motion_done, .homing_valid, .class0_active, .fault_active,
      .warn_src, .warn_code, .warn_code_vld, .err_clear, .reg_addr, .reg_rdata, .reg_hit,
      .cur_state, .mbox_on, .in_upd_on, .out_upd_on, .boot_mode, .dev_restart, .req_refused,
      .in_pd_valid, .in_pd_word, .out_apply_valid, .out_apply_data, .status_valid,
      .status_word);
   // 20 mhz clock
   always #25 clk = ~clk;
   // all driving lands 1 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // request, then check state, services and pulses
   task automatic step(input fss_pkg::fss_state_type st, input fss_pkg::fss_state_type es,
      input logic [2:0] sv, input logic [2:0] fl);
      master_u.request(st);
      `FSS_CHK("state", es, cur_state)
      `FSS_CHK("services", sv, {mbox_on, in_upd_on, out_upd_on})
      `FSS_CHK("refused_boot_restart", fl, {req_refused, boot_mode, dev_restart})
   endtask
   // register read, answer one cycle later
   task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic h);
      reg_addr = a;
      tick(1);
      `FSS_CHK("reg_rdata", e, reg_rdata)
      `FSS_CHK("reg_hit", h, reg_hit)
   endtask
   // bounded wait for a status send
   task automatic wait_sv();
      int i;
      for (i = 0; i < 20 && status_valid !== 1'b1; i++) begin
         tick(1);
      end
      if (status_valid !== 1'b1) begin
         n_mismatch++;
         $display("unexpected status_valid exp 1 got 0");
         summarize();
      end
   endtask
   task automatic t_bring_up();
      step(st_p, st_p, 3'b100, 3'b000);
      step(st_s, st_p, 3'b100, 3'b100);
      map_valid = 1'b1;
      step(st_s, st_s, 3'b110, 3'b000);
      tick(1);
      `FSS_CHK("in_pd", {1'b1, 16'h1234}, {in_pd_valid, in_pd_word})
      master_u.send_out(16'h00aa);
      `FSS_CHK("out_drop", 1'b0, out_apply_valid)
      $display("test bring_up done");
   endtask
   task automatic t_status();
      class0_active = 1'b1;
      wait_sv();
      `FSS_CHK("sw_err", 2'b10, {status_word[7], status_word[13]})
      tick(3);
      `FSS_CHK("sw_held", 1'b1, status_valid)
      stall = 1'b0;
      tick(2);
      `FSS_CHK("sw_resend", 1'b0, status_valid)
      stall = 1'b1;
      {drv_state_bits, volt_enabled, pause_active, mode_bits} = {4'ha, 1'b1, 1'b1, 2'h3};
      {motion_done, homing_valid, class0_active, fault_active} = 4'hd;
      wait_sv();
      `FSS_CHK("sw_word", 16'hf51a, status_word)
      rd(16'h1b04, 16'hf51a, 1'b1);
      stall = 1'b0;
      $display("test status done");
   endtask
   task automatic t_run();
      step(st_o, st_o, 3'b111, 3'b000);
      master_u.send_out(16'h5a5a);
      `FSS_CHK("out_apply", {1'b1, 16'h5a5a}, {out_apply_valid, out_apply_data})
      step(st_p, st_p, 3'b100, 3'b000);
      step(st_s, st_s, 3'b110, 3'b000);
      step(st_o, st_o, 3'b111, 3'b000);
      step(st_i, st_i, 3'b000, 3'b000);
      step(st_p, st_p, 3'b100, 3'b000);
      step(st_s, st_s, 3'b110, 3'b000);
      step(st_i, st_i, 3'b000, 3'b000);
      step(st_o, st_i, 3'b000, 3'b100);
      step(st_b, st_b, 3'b000, 3'b010);
      step(st_i, st_i, 3'b000, 3'b001);
      step(st_p, st_p, 3'b100, 3'b000);
      step(st_p, st_p, 3'b100, 3'b000);
      step(st_s, st_s, 3'b110, 3'b000);
      step(st_o, st_o, 3'b111, 3'b000);
      step(st_s, st_s, 3'b110, 3'b000);
      step(st_p, st_p, 3'b100, 3'b000);
      step(st_i, st_i, 3'b000, 3'b000);
      $display("test run done");
   endtask
   task automatic t_warn();
      warn_src = 16'h0802;
      tick(1);
      rd(16'h1c18, 16'h0802, 1'b1);
      warn_src = 16'h0000;
      tick(1);
      rd(16'h1c18, 16'h0002, 1'b1);
      err_clear = 1'b1;
      tick(1);
      err_clear = 1'b0;
      rd(16'h1c18, 16'h0000, 1'b1);
      warn_src = 16'h8008;
      tick(1);
      rd(16'h1c18, 16'h0000, 1'b1);
      {warn_src, warn_code, warn_code_vld} = {16'h0000, 16'h0123, 1'b1};
      tick(1);
      warn_code_vld = 1'b0;
      rd(16'h1c1a, 16'h0123, 1'b1);
      err_clear = 1'b1;
      tick(1);
      err_clear = 1'b0;
      rd(16'h1c1a, 16'h0000, 1'b1);
      rd(16'h0010, 16'h0000, 1'b0);
      $display("test warn done");
   endtask
   // frozen clock enable, then a reset taken from pre-op
   task automatic t_freeze();
      clk_en = 1'b0;
      step(st_p, st_i, 3'b000, 3'b000);
      clk_en = 1'b1;
      step(st_p, st_p, 3'b100, 3'b000);
      sys_rst = 1'b1;
      tick(1);
      sys_rst = 1'b0;
      `FSS_CHK("reset", {st_i, 3'b000}, {cur_state, mbox_on, in_upd_on, out_upd_on})
      step(st_p, st_p, 3'b100, 3'b000);
      $display("test freeze done");
   endtask
   // single place where the run ends
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // reset for 12 cycles, then the scenarios
   initial begin
      repeat (12) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      t_bring_up();
      t_status();
      t_run();
      t_warn();
      t_freeze();
      summarize();
   end
endmodule // fss_top_test
`default_nettype wire
